/* pkg/dspr_pkg.sv */
// Shared constants, types and arithmetic helpers for the audio DSP routing core.
package dspr_pkg;

  localparam int SW     = 24;
  localparam int CW     = 16;
  localparam int FRAC   = 14;
  localparam int WIDE   = 48;
  localparam int NBANDS = 5;
  localparam int COEF_N = 40;

  typedef struct packed {
    logic signed [SW-1:0] left;
    logic signed [SW-1:0] right;
  } dspr_stereo_type;

  typedef struct packed {
    logic signed [CW-1:0] c1;
    logic signed [CW-1:0] c2;
    logic signed [CW-1:0] c3;
  } dspr_coef_type;

  localparam logic [7:0] ADDR_LEVEL      = 8'h1d;
  localparam logic [7:0] ADDR_LIMIT      = 8'h1e;
  localparam logic [7:0] ADDR_GATE       = 8'h1f;
  localparam logic [7:0] ADDR_ARRANGE    = 8'h40;
  localparam logic [7:0] ADDR_LOWHIGH    = 8'h41;
  localparam logic [7:0] ADDR_LOWHIGH_K  = 8'h42;
  localparam logic [7:0] ADDR_WIDEN      = 8'h44;
  localparam logic [7:0] ADDR_WIDEN_D    = 8'h45;
  localparam logic [7:0] ADDR_BANDSTOP   = 8'h47;
  localparam logic [7:0] ADDR_BS_COEF    = 8'h48;
  localparam logic [7:0] ADDR_BS_LAST    = 8'h56;
  localparam logic [7:0] ADDR_DIRECTFORM = 8'h5c;
  localparam logic [7:0] ADDR_DF_COEF    = 8'h5d;
  localparam logic [7:0] ADDR_DF_LAST    = 8'h5f;
  localparam logic [7:0] ADDR_DCBLOCK    = 8'h63;
  localparam logic [7:0] ADDR_COMP       = 8'h64;
  localparam logic [7:0] ADDR_CP_COEF    = 8'h65;
  localparam logic [7:0] ADDR_CP_LAST    = 8'h67;
  localparam logic [7:0] ADDR_EQ         = 8'h85;
  localparam logic [7:0] ADDR_EQ_COEF    = 8'h86;
  localparam logic [7:0] ADDR_EQ_LAST    = 8'h94;

  localparam logic [5:0] SLOT_BS    = 6'h00;
  localparam logic [5:0] SLOT_DF    = 6'h0f;
  localparam logic [5:0] SLOT_CP    = 6'h12;
  localparam logic [5:0] SLOT_EQ    = 6'h15;
  localparam logic [5:0] SLOT_LH_K  = 6'h24;
  localparam logic [5:0] SLOT_DEPTH = 6'h25;
  localparam logic [5:0] SLOT_LIMIT = 6'h26;
  localparam logic [5:0] SLOT_GATE  = 6'h27;

  localparam int BIT_LEFT     = 0;
  localparam int BIT_RIGHT    = 1;
  localparam int BIT_MODE     = 2;
  localparam int BIT_LEVEL_EN = 7;
  localparam int BIT_ACTIVE   = 0;

  localparam logic [3:0] ARR_RECORD   = 4'h0;
  localparam logic [3:0] ARR_PLAYBACK = 4'h1;
  localparam logic [3:0] ARR_GENERAL1 = 4'h2;
  localparam logic [3:0] ARR_GENERAL2 = 4'h3;
  localparam logic [3:0] ARR_RST      = 4'h0;

  localparam logic signed [CW-1:0] COEF_ONE  = 16'sh4000;
  localparam logic signed [CW-1:0] LIMIT_RST = 16'sh7fff;
  // Fixed 3.7 Hz high-pass pole, 1 - 2*pi*3.7/48000 in Q14.
  localparam logic signed [CW-1:0] DC_A      = 16'sh3ff8;
  localparam dspr_coef_type        DC_COEF   = '{DC_A, -DC_A, DC_A};

  function automatic logic signed [WIDE-1:0] dspr_mulq(input logic signed [SW:0] x,
                                                      input logic signed [CW-1:0] c);
    dspr_mulq = (WIDE'(x) * WIDE'(c)) >>> FRAC;
  endfunction : dspr_mulq

  function automatic logic signed [SW-1:0] dspr_sat(input logic signed [WIDE-1:0] v);
    logic signed [WIDE-1:0] hi;
    logic signed [WIDE-1:0] lo;
    hi = WIDE'({1'b0, {(SW-1){1'b1}}});
    lo = -hi - WIDE'(1);
    if (v > hi) dspr_sat = hi[SW-1:0];
    else if (v < lo) dspr_sat = lo[SW-1:0];
    else dspr_sat = v[SW-1:0];
  endfunction : dspr_sat

endpackage : dspr_pkg

/* src/dspr_section.sv */
// First-order direct-form section with bypass, the building block of every filter stage.
`timescale 1ns/1ns
module dspr_section (
  input  wire logic                           core_clk_i,
  input  wire logic                           rstn_i,
  input  wire logic                           adv_i,
  input  wire logic                           en_i,
  input  wire logic signed [dspr_pkg::SW-1:0] x_i,
  input  dspr_pkg::dspr_coef_type             coef_i,
  output logic signed      [dspr_pkg::SW-1:0] y_o
);

  logic signed [dspr_pkg::SW-1:0]   x1;
  logic signed [dspr_pkg::SW-1:0]   y1;
  logic signed [dspr_pkg::SW-1:0]   next_x1;
  logic signed [dspr_pkg::SW-1:0]   next_y1;
  logic signed [dspr_pkg::WIDE-1:0] acc;

  always_comb begin
    acc = dspr_pkg::dspr_mulq((dspr_pkg::SW+1)'(x_i), coef_i.c1)
        + dspr_pkg::dspr_mulq((dspr_pkg::SW+1)'(x1), coef_i.c2)
        + dspr_pkg::dspr_mulq((dspr_pkg::SW+1)'(y1), coef_i.c3);
    // A disabled section keeps tracking its input so re-enabling starts without a step.
    y_o = en_i ? dspr_pkg::dspr_sat(acc) : x_i;
    next_x1 = adv_i ? x_i : x1;
    next_y1 = adv_i ? y_o : y1;
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      x1 <= '0;
      y1 <= '0;
    end else begin
      x1 <= next_x1;
      y1 <= next_y1;
    end
  end

endmodule : dspr_section

/* src/dspr_core.sv */
// Audio DSP core: register file, path arrangement routing and the three enhancement stages.
`timescale 1ns/1ns
// How it works
// - Four-bit arrangement field picks record, playback, general one or general two routing.
// - Record arrangement puts every enhancement stage in the microphone to interface path.
// - Record arrangement keeps a plain unprocessed playback path to the converter.
// - Playback arrangement puts every stage in the interface to converter path.
// - Playback arrangement keeps a plain unprocessed record path to the interface.
// - Stage one filters and widening, stage two equalising, stage three level control.
// - Stereo microphone path exists; mono analogue samples use the left channel.
// - Stage-one first-order filter is low-pass, high-pass or bypassed, bypassed after reset.
// - Widening stage, off at reset, can output a mono left plus right mix.
// - Left and right widening enables work independently of each other.
// - Five band-stop sections, separate channel enables, one shared coefficient set.
// - Direct-form output is c1 times input plus c2 old input plus c3 old output.
// - Reset coefficients make the direct-form filter pass samples unchanged.
// - Stage-two high-pass has a fixed 3.7Hz cut-off and per-channel enables.
// - Equalizer has five bands with programmable frequency and gain, on the left channel only.
// - Stage three limits and gates the level, set by its own registers.
// - Each sub-block enable only switches it on or off and resets to off.
module dspr_core (
  input  wire logic                           core_clk_i,
  input  wire logic                           rstn_i,
  input  wire logic                           ce_i,
  input  wire logic                           reg_wr_i,
  input  wire logic [7:0]                     reg_addr_i,
  input  wire logic [15:0]                    reg_wdata_i,
  output logic      [15:0]                    reg_rd_data_o,
  input  wire logic                           mic_source_dmic_i,
  input  wire logic                           adc_valid_i,
  input  wire logic signed [dspr_pkg::SW-1:0] adc_data_i,
  output logic                                adc_ready_o,
  input  wire logic                           dmic_valid_i,
  input  dspr_pkg::dspr_stereo_type           dmic_data_i,
  output logic                                dmic_ready_o,
  input  wire logic                           aif_rx_valid_i,
  input  dspr_pkg::dspr_stereo_type           aif_rx_data_i,
  output logic                                aif_rx_ready_o,
  output logic                                aif_tx_valid_o,
  output dspr_pkg::dspr_stereo_type           aif_tx_data_o,
  input  wire logic                           aif_tx_ready_i,
  output logic                                dac_valid_o,
  output logic signed      [dspr_pkg::SW-1:0] dac_data_o,
  input  wire logic                           dac_ready_i
);

  localparam int SW   = dspr_pkg::SW;
  localparam int WIDE = dspr_pkg::WIDE;

  function automatic logic [6:0] slot_of(input logic [7:0] a);
    slot_of = 7'h00;
    if (a >= dspr_pkg::ADDR_BS_COEF && a <= dspr_pkg::ADDR_BS_LAST)
      slot_of = {1'b1, 6'(a - dspr_pkg::ADDR_BS_COEF) + dspr_pkg::SLOT_BS};
    else if (a >= dspr_pkg::ADDR_DF_COEF && a <= dspr_pkg::ADDR_DF_LAST)
      slot_of = {1'b1, 6'(a - dspr_pkg::ADDR_DF_COEF) + dspr_pkg::SLOT_DF};
    else if (a >= dspr_pkg::ADDR_CP_COEF && a <= dspr_pkg::ADDR_CP_LAST)
      slot_of = {1'b1, 6'(a - dspr_pkg::ADDR_CP_COEF) + dspr_pkg::SLOT_CP};
    else if (a >= dspr_pkg::ADDR_EQ_COEF && a <= dspr_pkg::ADDR_EQ_LAST)
      slot_of = {1'b1, 6'(a - dspr_pkg::ADDR_EQ_COEF) + dspr_pkg::SLOT_EQ};
    else if (a == dspr_pkg::ADDR_LOWHIGH_K) slot_of = {1'b1, dspr_pkg::SLOT_LH_K};
    else if (a == dspr_pkg::ADDR_WIDEN_D) slot_of = {1'b1, dspr_pkg::SLOT_DEPTH};
    else if (a == dspr_pkg::ADDR_LIMIT) slot_of = {1'b1, dspr_pkg::SLOT_LIMIT};
    else if (a == dspr_pkg::ADDR_GATE) slot_of = {1'b1, dspr_pkg::SLOT_GATE};
  endfunction : slot_of

  // Every triple of filter coefficients resets to pass-through: c1 one, c2 and c3 zero.
  function automatic logic signed [dspr_pkg::CW-1:0] coef_reset(input int i);
    if (i < int'(dspr_pkg::SLOT_LH_K) && (i % 3) == 0) coef_reset = dspr_pkg::COEF_ONE;
    else if (i == int'(dspr_pkg::SLOT_LIMIT)) coef_reset = dspr_pkg::LIMIT_RST;
    else coef_reset = '0;
  endfunction : coef_reset

  // Bit 0, 1, 2 set means stage one, two, three sits in the record path.
  function automatic logic [2:0] on_record(input logic [3:0] m);
    case (m)
      dspr_pkg::ARR_RECORD:   on_record = 3'h7;
      dspr_pkg::ARR_PLAYBACK: on_record = 3'h0;
      dspr_pkg::ARR_GENERAL1: on_record = 3'h1;
      dspr_pkg::ARR_GENERAL2: on_record = 3'h3;
      default:                on_record = 3'h7;
    endcase
  endfunction : on_record

  function automatic dspr_pkg::dspr_coef_type triple(input int base,
                                                      input logic [15:0] c0,
                                                      input logic [15:0] c1,
                                                      input logic [15:0] c2);
    triple = '{c0, c1, c2};
  endfunction : triple

  // Register file.
  logic [3:0]                     arrange;
  logic [2:0]                     lowhigh;
  logic [2:0]                     widen;
  logic [1:0]                     bandstop;
  logic [1:0]                     directform;
  logic [1:0]                     dcblock;
  logic [1:0]                     comp;
  logic                           eq_left;
  logic                           level_en;
  logic                           level_active;
  logic [15:0]                    coef [dspr_pkg::COEF_N];
  logic [3:0]                     next_arrange;
  logic [2:0]                     next_lowhigh;
  logic [2:0]                     next_widen;
  logic [1:0]                     next_bandstop;
  logic [1:0]                     next_directform;
  logic [1:0]                     next_dcblock;
  logic [1:0]                     next_comp;
  logic                           next_eq_left;
  logic                           next_level_en;
  logic                           next_level_active;
  logic [15:0]                    next_coef [dspr_pkg::COEF_N];
  logic [15:0]                    next_rd_data;
  logic [6:0]                     slot;
  logic [1:0]                     clip;

  always_comb begin
    slot = slot_of(reg_addr_i);
    next_arrange = arrange;
    next_lowhigh = lowhigh;
    next_widen = widen;
    next_bandstop = bandstop;
    next_directform = directform;
    next_dcblock = dcblock;
    next_comp = comp;
    next_eq_left = eq_left;
    next_level_en = level_en;
    next_coef = coef;
    if (reg_wr_i) begin
      case (reg_addr_i)
        dspr_pkg::ADDR_ARRANGE:    next_arrange = reg_wdata_i[3:0];
        dspr_pkg::ADDR_LOWHIGH:    next_lowhigh = reg_wdata_i[2:0];
        dspr_pkg::ADDR_WIDEN:      next_widen = reg_wdata_i[2:0];
        dspr_pkg::ADDR_BANDSTOP:   next_bandstop = reg_wdata_i[1:0];
        dspr_pkg::ADDR_DIRECTFORM: next_directform = reg_wdata_i[1:0];
        dspr_pkg::ADDR_DCBLOCK:    next_dcblock = reg_wdata_i[1:0];
        dspr_pkg::ADDR_COMP:       next_comp = reg_wdata_i[1:0];
        dspr_pkg::ADDR_EQ:         next_eq_left = reg_wdata_i[0];
        dspr_pkg::ADDR_LEVEL:      next_level_en = reg_wdata_i[dspr_pkg::BIT_LEVEL_EN];
        default:                   next_coef[slot[5:0]] = slot[6] ? reg_wdata_i : coef[slot[5:0]];
      endcase
    end
    case (reg_addr_i)
      dspr_pkg::ADDR_ARRANGE:    next_rd_data = {12'h000, arrange};
      dspr_pkg::ADDR_LOWHIGH:    next_rd_data = {13'h0000, lowhigh};
      dspr_pkg::ADDR_WIDEN:      next_rd_data = {13'h0000, widen};
      dspr_pkg::ADDR_BANDSTOP:   next_rd_data = {14'h0000, bandstop};
      dspr_pkg::ADDR_DIRECTFORM: next_rd_data = {14'h0000, directform};
      dspr_pkg::ADDR_DCBLOCK:    next_rd_data = {14'h0000, dcblock};
      dspr_pkg::ADDR_COMP:       next_rd_data = {14'h0000, comp};
      dspr_pkg::ADDR_EQ:         next_rd_data = {15'h0000, eq_left};
      dspr_pkg::ADDR_LEVEL:      next_rd_data = {8'h00, level_en, 6'h00, level_active};
      default:                   next_rd_data = slot[6] ? coef[slot[5:0]] : 16'h0000;
    endcase
  end

  // Stream front end and routing.
  logic [2:0]                     on_rec;
  logic [1:0]                     room;
  logic                           rec_fire;
  logic                           play_fire;
  logic                           s1_adv;
  logic                           s2_adv;
  logic                           s3_adv;
  dspr_pkg::dspr_stereo_type      rec_in;
  logic signed [SW-1:0]           rec_x [2];
  logic signed [SW-1:0]           play_x [2];
  logic signed [SW-1:0]           s1_x [2];
  logic signed [SW-1:0]           s1_y [2];
  logic signed [SW-1:0]           r1 [2];
  logic signed [SW-1:0]           p1 [2];
  logic signed [SW-1:0]           s2_x [2];
  logic signed [SW-1:0]           s2_y [2];
  logic signed [SW-1:0]           r2 [2];
  logic signed [SW-1:0]           p2 [2];
  logic signed [SW-1:0]           s3_x [2];
  logic signed [SW-1:0]           s3_y [2];
  logic signed [SW-1:0]           rec_out [2];
  logic signed [SW-1:0]           play_out [2];
  logic signed [SW-1:0]           lh_y [2];
  logic signed [SW-1:0]           wd_y [2];
  logic signed [SW-1:0]           bs_y [2][dspr_pkg::NBANDS+1];
  logic signed [SW-1:0]           dc_y [2];
  logic signed [SW-1:0]           cp_y [2];
  logic signed [SW-1:0]           eq_y [2][dspr_pkg::NBANDS+1];
  logic signed [dspr_pkg::CW-1:0] lh_k;
  logic signed [dspr_pkg::CW-1:0] lh_a;
  dspr_pkg::dspr_coef_type        lh_coef;

  assign on_rec = on_record(arrange);
  // A stalled output buffer refuses new samples instead of dropping them.
  assign adc_ready_o = ce_i & ~mic_source_dmic_i & room[0];
  assign dmic_ready_o = ce_i & mic_source_dmic_i & room[0];
  assign aif_rx_ready_o = ce_i & room[1];
  assign rec_fire = mic_source_dmic_i ? (dmic_valid_i & dmic_ready_o)
                                      : (adc_valid_i & adc_ready_o);
  assign play_fire = aif_rx_valid_i & aif_rx_ready_o;
  assign rec_in = mic_source_dmic_i ? dmic_data_i
                                    : dspr_pkg::dspr_stereo_type'{adc_data_i, '0};
  assign s1_adv = on_rec[0] ? rec_fire : play_fire;
  assign s2_adv = on_rec[1] ? rec_fire : play_fire;
  assign s3_adv = on_rec[2] ? rec_fire : play_fire;
  assign lh_k = coef[dspr_pkg::SLOT_LH_K];
  assign lh_a = dspr_pkg::COEF_ONE - lh_k;
  assign lh_coef = lowhigh[dspr_pkg::BIT_MODE] ? dspr_pkg::dspr_coef_type'{lh_a, -lh_a, lh_a}
                                               : dspr_pkg::dspr_coef_type'{lh_k, '0, lh_a};

  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic signed [dspr_pkg::WIDE-1:0] wd_sum;
    logic signed [dspr_pkg::WIDE-1:0] mono;
    logic signed [SW-1:0]             mag;

    assign rec_x[c] = (c == 0) ? rec_in.left : rec_in.right;
    assign play_x[c] = (c == 0) ? aif_rx_data_i.left : aif_rx_data_i.right;
    // Each stage sits in exactly one path; the other path bypasses it untouched.
    assign s1_x[c] = on_rec[0] ? rec_x[c] : play_x[c];
    assign r1[c] = on_rec[0] ? s1_y[c] : rec_x[c];
    assign p1[c] = on_rec[0] ? play_x[c] : s1_y[c];
    assign s2_x[c] = on_rec[1] ? r1[c] : p1[c];
    assign r2[c] = on_rec[1] ? s2_y[c] : r1[c];
    assign p2[c] = on_rec[1] ? p1[c] : s2_y[c];
    assign s3_x[c] = on_rec[2] ? r2[c] : p2[c];
    assign rec_out[c] = on_rec[2] ? s3_y[c] : r2[c];
    assign play_out[c] = on_rec[2] ? p2[c] : s3_y[c];

    dspr_section u_lowhigh (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .adv_i(s1_adv),
      .en_i(lowhigh[c]), .x_i(s1_x[c]), .coef_i(lh_coef), .y_o(lh_y[c]));

    assign wd_sum = WIDE'(lh_y[c]) + dspr_pkg::dspr_mulq((SW+1)'(lh_y[c]) - (SW+1)'(lh_y[1-c]),
                                                         coef[dspr_pkg::SLOT_DEPTH]);
    assign mono = (WIDE'(lh_y[0]) + WIDE'(lh_y[1])) >>> 1;
    assign wd_y[c] = !widen[c] ? lh_y[c]
                   : dspr_pkg::dspr_sat(widen[dspr_pkg::BIT_MODE] ? mono : wd_sum);

    assign bs_y[c][0] = wd_y[c];
    assign eq_y[c][0] = cp_y[c];
    for (genvar b = 0; b < dspr_pkg::NBANDS; b++) begin : g_band
      dspr_section u_bandstop (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .adv_i(s1_adv),
        .en_i(bandstop[c]), .x_i(bs_y[c][b]),
        .coef_i(triple(b, coef[3*b], coef[3*b+1], coef[3*b+2])), .y_o(bs_y[c][b+1]));
      dspr_section u_eq (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .adv_i(s2_adv),
        .en_i((c == 0) && eq_left), .x_i(eq_y[c][b]),
        .coef_i(triple(b, coef[int'(dspr_pkg::SLOT_EQ)+3*b],
                       coef[int'(dspr_pkg::SLOT_EQ)+3*b+1],
                       coef[int'(dspr_pkg::SLOT_EQ)+3*b+2])),
        .y_o(eq_y[c][b+1]));
    end

    dspr_section u_directform (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .adv_i(s1_adv),
      .en_i(directform[c]), .x_i(bs_y[c][dspr_pkg::NBANDS]),
      .coef_i(triple(0, coef[dspr_pkg::SLOT_DF], coef[dspr_pkg::SLOT_DF+6'h01],
                     coef[dspr_pkg::SLOT_DF+6'h02])), .y_o(s1_y[c]));
    dspr_section u_dcblock (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .adv_i(s2_adv),
      .en_i(dcblock[c]), .x_i(s2_x[c]), .coef_i(dspr_pkg::DC_COEF), .y_o(dc_y[c]));
    dspr_section u_comp (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .adv_i(s2_adv),
      .en_i(comp[c]), .x_i(dc_y[c]),
      .coef_i(triple(0, coef[dspr_pkg::SLOT_CP], coef[dspr_pkg::SLOT_CP+6'h01],
                     coef[dspr_pkg::SLOT_CP+6'h02])), .y_o(cp_y[c]));
    assign s2_y[c] = eq_y[c][dspr_pkg::NBANDS];

    // Hard limiter and noise gate compare the top 16 magnitude bits against the thresholds.
    assign mag = s3_x[c][SW-1] ? -s3_x[c] : s3_x[c];
    assign clip[c] = level_en && (mag[SW-1:SW-16] > coef[dspr_pkg::SLOT_LIMIT]);
    assign s3_y[c] = !level_en ? s3_x[c]
                   : clip[c] ? (s3_x[c][SW-1] ? -{coef[dspr_pkg::SLOT_LIMIT], 8'h00}
                                              : {coef[dspr_pkg::SLOT_LIMIT], 8'h00})
                   : (mag[SW-1:SW-16] < coef[dspr_pkg::SLOT_GATE]) ? '0
                   : s3_x[c];
  end

  assign next_level_active = s3_adv ? |clip : level_active;

  // Two-entry output buffers: index 0 feeds the interface, index 1 feeds the converter.
  dspr_pkg::dspr_stereo_type buf_mem [2][2];
  dspr_pkg::dspr_stereo_type next_buf_mem [2][2];
  logic [1:0]                buf_cnt [2];
  logic [1:0]                next_buf_cnt [2];
  logic [1:0]                buf_wr;
  logic [1:0]                buf_rd;
  logic [1:0]                next_buf_wr;
  logic [1:0]                next_buf_rd;
  logic [1:0]                push;
  logic [1:0]                pop;

  assign push = {play_fire, rec_fire};
  assign pop = {ce_i & dac_valid_o & dac_ready_i, ce_i & aif_tx_valid_o & aif_tx_ready_i};

  always_comb begin
    next_buf_mem = buf_mem;
    for (int p = 0; p < 2; p++) begin
      room[p] = buf_cnt[p] != 2'h2;
      next_buf_wr[p] = buf_wr[p] ^ push[p];
      next_buf_rd[p] = buf_rd[p] ^ pop[p];
      next_buf_cnt[p] = buf_cnt[p] + 2'(push[p]) - 2'(pop[p]);
    end
    if (push[0]) next_buf_mem[0][buf_wr[0]] = '{rec_out[0], rec_out[1]};
    if (push[1]) next_buf_mem[1][buf_wr[1]] = '{play_out[0], play_out[1]};
  end

  assign aif_tx_valid_o = buf_cnt[0] != 2'h0;
  assign aif_tx_data_o = buf_mem[0][buf_rd[0]];
  assign dac_valid_o = buf_cnt[1] != 2'h0;
  assign dac_data_o = buf_mem[1][buf_rd[1]].left;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      arrange <= dspr_pkg::ARR_RST;
      lowhigh <= 3'h0;
      widen <= 3'h0;
      bandstop <= 2'h0;
      directform <= 2'h0;
      dcblock <= 2'h0;
      comp <= 2'h0;
      eq_left <= 1'b0;
      level_en <= 1'b0;
      level_active <= 1'b0;
      reg_rd_data_o <= 16'h0000;
      for (int i = 0; i < dspr_pkg::COEF_N; i++) coef[i] <= coef_reset(i);
      buf_mem <= '{default: '0};
      buf_cnt <= '{default: 2'h0};
      buf_wr <= 2'h0;
      buf_rd <= 2'h0;
    end else if (ce_i) begin
      arrange <= next_arrange;
      lowhigh <= next_lowhigh;
      widen <= next_widen;
      bandstop <= next_bandstop;
      directform <= next_directform;
      dcblock <= next_dcblock;
      comp <= next_comp;
      eq_left <= next_eq_left;
      level_en <= next_level_en;
      level_active <= next_level_active;
      reg_rd_data_o <= next_rd_data;
      coef <= next_coef;
      buf_mem <= next_buf_mem;
      buf_cnt <= next_buf_cnt;
      buf_wr <= next_buf_wr;
      buf_rd <= next_buf_rd;
    end
  end

endmodule : dspr_core

/* test/dspr_core_checker.sv */
// Port-level checker for the routing core.
`timescale 1ns/1ns
module dspr_core_checker (
  input wire logic                           core_clk_i, rstn_i, ce_i, reg_wr_i,
  input wire logic                           mic_source_dmic_i, adc_valid_i, adc_ready_o,
  input wire logic                           dac_ready_i, dmic_ready_o, aif_rx_valid_i,
  input wire logic                           aif_rx_ready_o,
  input wire logic                           aif_tx_valid_o, aif_tx_ready_i, dac_valid_o,
  input wire logic [7:0]                     reg_addr_i,
  input wire logic [15:0]                    reg_wdata_i, reg_rd_data_o,
  input dspr_pkg::dspr_stereo_type           aif_tx_data_o,
  input wire logic signed [dspr_pkg::SW-1:0] dac_data_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  property p_adc_src; adc_ready_o |-> ce_i && !mic_source_dmic_i; endproperty
  a_adc_src: assert property (p_adc_src) else $error("adc ready with dmic source");
  property p_dmic_src; dmic_ready_o |-> ce_i && mic_source_dmic_i; endproperty
  a_dmic_src: assert property (p_dmic_src) else $error("dmic ready with adc source");
  property p_tx_rise; adc_valid_i && adc_ready_o |=> aif_tx_valid_o; endproperty
  a_tx_rise: assert property (p_tx_rise) else $error("record word not offered");
  property p_dac_rise; aif_rx_valid_i && aif_rx_ready_o |=> dac_valid_o; endproperty
  a_dac_rise: assert property (p_dac_rise) else $error("playback word not offered");
  property p_tx_hold;
    aif_tx_valid_o && !aif_tx_ready_i |=> aif_tx_valid_o && $stable(aif_tx_data_o);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("record word lost in stall");
  property p_dac_hold; dac_valid_o && !dac_ready_i |=> dac_valid_o && $stable(dac_data_o);
  endproperty
  a_dac_hold: assert property (p_dac_hold) else $error("playback word lost in stall");
  property p_arr_rd;
    ce_i && reg_wr_i && reg_addr_i == 8'h40 ##1 ce_i && !reg_wr_i && reg_addr_i == 8'h40
    |=> reg_rd_data_o == ($past(reg_wdata_i, 2) & 16'h000f);
  endproperty
  a_arr_rd: assert property (p_arr_rd) else $error("arrangement readback wrong");
  property p_unmap; ce_i && reg_addr_i == 8'h21 |=> reg_rd_data_o == 16'h0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  c_full: cover property (ce_i && !mic_source_dmic_i && !adc_ready_o);
  c_tx: cover property (aif_tx_valid_o && aif_tx_ready_i);
  c_dac: cover property (dac_valid_o && dac_ready_i);
endmodule : dspr_core_checker
bind dspr_core dspr_core_checker u_chk (.*);

/* test/dspr_far_end.sv */
// Far-side sink for the interface transmitter and the playback converter.
`timescale 1ns/1ns
module dspr_far_end (
  input  wire logic core_clk_i,
  input  wire logic hold_i,
  output logic      aif_tx_ready_o = 1'b0,
  output logic      dac_ready_o = 1'b0
);
  integer seed = 32'h76bd;
  // Random stalls exercise both buffers; hold_i stops both sinks so a buffer can fill.
  always @(negedge core_clk_i)
    {aif_tx_ready_o, dac_ready_o} <= hold_i ? 2'b00 : 2'($random(seed));
endmodule : dspr_far_end

/* test/audio_dsp_core_routing_bench.sv */
// Self-checking bench for the routing core: registers, arrangements and stream buffers.
`timescale 1ns/1ns
module audio_dsp_core_routing_bench;
  logic core_clk_i = 1'b0, rstn_i = 1'b0, ce_i = 1'b1, reg_wr_i = 1'b0, hold = 1'b0;
  logic mic_source_dmic_i = 1'b0, adc_valid_i = 1'b0, dmic_valid_i = 1'b0;
  logic aif_rx_valid_i = 1'b0, aif_tx_ready_i, dac_ready_i, adc_ready_o, dmic_ready_o;
  logic aif_rx_ready_o, aif_tx_valid_o, dac_valid_o;
  logic [7:0] reg_addr_i = 8'h00;
  logic [15:0] reg_wdata_i = 16'h0000, reg_rd_data_o;
  logic signed [dspr_pkg::SW-1:0] adc_data_i = 24'h000000, dac_data_o, x;
  dspr_pkg::dspr_stereo_type dmic_data_i = 48'h0, aif_rx_data_i = 48'h0, aif_tx_data_o;
  logic [47:0] q_rec[$], q_pb[$];
  integer num_errors = 0, cmp_count = 0, seed = 32'h76bd, a, i;
  initial forever #10 core_clk_i = ~core_clk_i;
  dspr_core dut (.*);
  dspr_far_end far (.core_clk_i, .hold_i(hold), .aif_tx_ready_o(aif_tx_ready_i),
                    .dac_ready_o(dac_ready_i));
  task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] ad, input logic [15:0] d);
    @(negedge core_clk_i) {reg_wr_i, reg_addr_i, reg_wdata_i} = {1'b1, ad, d};
    @(negedge core_clk_i) reg_wr_i = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] ad, input logic [15:0] e);
    reg_addr_i = ad;
    @(negedge core_clk_i) chk("register", 48'(reg_rd_data_o), 48'(e));
  endtask : rd
  // Halving through c1 = 0.5 shows whether stage one sits in the path.
  function automatic logic [23:0] f(input logic signed [23:0] v, input logic h);
    f = h ? 24'(v >>> 1) : v;
  endfunction : f
  task automatic rec(input logic h);
    x = $random(seed);
    {adc_data_i, dmic_data_i} = {x, x, ~x};
    q_rec.push_back({f(x, h), mic_source_dmic_i ? f(~x, h) : 24'h000000});
    adc_valid_i = !mic_source_dmic_i;
    dmic_valid_i = mic_source_dmic_i;
    while (!(adc_ready_o || dmic_ready_o)) @(negedge core_clk_i);
    @(negedge core_clk_i) {adc_valid_i, dmic_valid_i} = 2'b00;
  endtask : rec
  task automatic pb(input logic h);
    x = $random(seed);
    aif_rx_data_i = {x, ~x};
    q_pb.push_back({24'h000000, f(x, h)});
    aif_rx_valid_i = 1'b1;
    while (!aif_rx_ready_o) @(negedge core_clk_i);
    @(negedge core_clk_i) aif_rx_valid_i = 1'b0;
  endtask : pb
  always @(posedge core_clk_i) begin
    if (rstn_i && ce_i && aif_tx_valid_o && aif_tx_ready_i)
      chk("record", aif_tx_data_o, q_rec.pop_front());
    if (rstn_i && ce_i && dac_valid_o && dac_ready_i)
      chk("playback", {24'h000000, dac_data_o}, q_pb.pop_front());
  end
  task automatic wrap_up;
    $display("compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (8) @(negedge core_clk_i);
    rstn_i = 1'b1;
    rd(8'h40, 16'h0000);
    rd(8'h5d, 16'h4000);
    rd(8'h21, 16'h0000);
    for (a = 0; a < 6; a++) begin
      if (a == 1) wr(8'h5c, 16'h0003);
      if (a == 2) wr(8'h5d, 16'h2000);
      if (a > 1) wr(8'h40, 16'(a - 2));
      if (a > 1) rd(8'h40, 16'(a - 2));
      for (i = 0; i < 6; i++) begin
        mic_source_dmic_i = i[0];
        rec(a > 1 && a != 3);
        pb(a == 3);
      end
    end
    mic_source_dmic_i = 1'b0;
    repeat (20) @(negedge core_clk_i);
    hold = 1'b1;
    repeat (2) @(negedge core_clk_i);
    rec(1'b1);
    // Let an edge pass so the valid is not lowered and raised in one step.
    @(negedge core_clk_i) rec(1'b1);
    chk("refuse", 48'(adc_ready_o), 48'h0);
    hold = 1'b0;
    repeat (20) @(negedge core_clk_i);
    ce_i = 1'b0;
    @(negedge core_clk_i) chk("freeze", 48'(aif_rx_ready_o), 48'h0);
    wrap_up();
  end
  initial begin
    #400000;
    num_errors++;
    wrap_up();
  end
endmodule : audio_dsp_core_routing_bench
